// ==== common/erb_pkg.sv ====
// erb_pkg: constants shared by the embedded ram block files
//**********************************************************************
// Functional notes
// RULE1 - true dual-port on mid/large: two reads, two writes, or one each at once
// RULE2 - simple dual-port: read and write together; read sees old data or don't-care
// RULE3 - single-port: no read beside write; bypassed output shows written data
// RULE4 - single-port registered output shows written data after the next rising edge
// RULE5 - address, write data and write enable are captured in input registers
// RULE6 - write strobe is self-timed from the clock, never shaped by user logic
// RULE7 - output registers are selectable for pipelining or bypassed
// RULE8 - small/mid simple dual-port flow-through: read regs on falling edge, bypassed
// RULE9 - the two ports may use different data widths
// RULE10 - small/mid clear input and output registers; large clears outputs only
// RULE11 - large block has no preload; user writes once then holds writes off
// RULE12 - mid block hosts two independent single-port memories of half size each
// RULE13 - wider memories are parallel blocks with shared addressing, no extra logic
// RULE14 - small/mid outputs are cleared at power-up; large may be undefined
//**********************************************************************
package erb_pkg;
   // block sizes
   localparam logic [1:0] ERB_SIZE_SMALL = 2'h0;
   localparam logic [1:0] ERB_SIZE_MID   = 2'h1;
   localparam logic [1:0] ERB_SIZE_LARGE = 2'h2;
   // port modes
   localparam logic [1:0] ERB_MODE_SDP = 2'h0;
   localparam logic [1:0] ERB_MODE_TDP = 2'h1;
   localparam logic [1:0] ERB_MODE_SP  = 2'h2;
   localparam logic [1:0] ERB_MODE_DSP = 2'h3;
   // apb register byte offsets
   localparam int         ERB_APB_AW   = 12;
   localparam logic [11:0] ERB_OFS_CTRL = 12'h000;
   localparam logic [11:0] ERB_OFS_STAT = 12'h004;
   localparam logic [11:0] ERB_OFS_CLR  = 12'h008;
   // control fields
   localparam int ERB_CTL_MODE  = 0;
   localparam int ERB_CTL_OREGA = 4;
   localparam int ERB_CTL_OREGB = 5;
   localparam int ERB_CTL_FLOW  = 6;
   localparam int ERB_CTL_OLD   = 7;
   localparam int ERB_CTL_WA    = 8;
   localparam int ERB_CTL_WB    = 12;
   localparam int ERB_WCW       = 3;
   localparam logic [31:0] ERB_CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] ERB_CTRL_MASK = 32'h0000_77f3;
   // clear command bits
   localparam int ERB_CLR_IN   = 0;
   localparam int ERB_CLR_OUT  = 1;
   localparam int ERB_CLR_FLAG = 2;
   // status fields
   localparam int ERB_ST_MODE  = 0;
   localparam int ERB_ST_FLOW  = 2;
   localparam int ERB_ST_CLASH = 3;
   localparam int ERB_ST_SIZE  = 4;
endpackage

// ==== hdl/erb_port.sv ====
// erb_port: one user port, input registers, read address and output register
`timescale 1ns/1ps
`default_nettype none
module erb_port
   import erb_pkg::*;
#(
   parameter int AW = 9,
   parameter int DW = 16
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          clr_in,
   input  wire logic          clr_out,
   input  wire logic          flow_sel,
   input  wire logic          oreg_sel,
   input  wire logic          wr_thru,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic          wren,
   input  wire logic          rden,
   input  wire logic [DW-1:0] arr_q,
   output logic               wren_ff,
   output logic      [AW-1:0] waddr_ff,
   output logic      [DW-1:0] wdata_ff,
   output logic      [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   logic [AW-1:0] raddr_p_ff;
   logic [AW-1:0] raddr_n_ff;
   logic [DW-1:0] q_ff;

   //******************************************************************
   // input registers
   //******************************************************************
   // write side captured every edge; the array writes one edge later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wren_ff  <= 1'b0;
         waddr_ff <= '0;
         wdata_ff <= '0;
      end else if (clr_in) begin // RULE10
         wren_ff  <= 1'b0;
         waddr_ff <= '0;
         wdata_ff <= '0;
      end else begin // RULE5
         wren_ff  <= wren;
         waddr_ff <= addr;
         wdata_ff <= wdata;
      end
   end

   // read address held between reads; a single-port write moves it too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raddr_p_ff <= '0;
      end else if (clr_in) begin
         raddr_p_ff <= '0;
      end else if (rden || (wr_thru && wren)) begin // RULE3
         raddr_p_ff <= addr;
      end
   end

   // falling-edge copy gives data before the next rising edge
   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
         raddr_n_ff <= '0;
      end else if (clr_in) begin
         raddr_n_ff <= '0;
      end else if (rden) begin // RULE8
         raddr_n_ff <= addr;
      end
   end

   assign raddr = flow_sel ? raddr_n_ff : raddr_p_ff; // RULE8

   //******************************************************************
   // output register
   //******************************************************************
   // cleared at reset so the port never shows stale bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_ff <= '0; // RULE14
      end else if (clr_out) begin
         q_ff <= '0; // RULE10
      end else begin
         q_ff <= arr_q;
      end
   end

   // flow-through forces the bypass whatever the select says
   assign rdata = (oreg_sel && !flow_sel) ? q_ff : arr_q; // RULE7 RULE4
endmodule // erb_port
`default_nettype wire

// ==== hdl/erb_ram.sv ====
// erb_ram: embedded ram block with apb configuration and two user ports
`timescale 1ns/1ps
`default_nettype none
module erb_ram
   import erb_pkg::*;
#(
   parameter logic [1:0] SIZE  = ERB_SIZE_SMALL,
   parameter int         DEPTH = 32,
   parameter int         DW    = 16,
   localparam int        TOT   = DEPTH * DW,
   localparam int        AW    = $clog2(TOT)
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [ERB_APB_AW-1:0] paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic           [31:0] pwdata,
   output logic                [31:0] prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic         [AW-1:0] a_addr,
   input  wire logic         [DW-1:0] a_wdata,
   input  wire logic                  a_wren,
   input  wire logic                  a_rden,
   output logic              [DW-1:0] a_rdata,
   input  wire logic         [AW-1:0] b_addr,
   input  wire logic         [DW-1:0] b_wdata,
   input  wire logic                  b_wren,
   input  wire logic                  b_rden,
   output logic              [DW-1:0] b_rdata
);
   localparam int LOG_DW = $clog2(DW);

   logic          [31:0] ctrl_ff;
   logic          [31:0] prdata_ff;
   logic          [31:0] stat_w;
   logic                 clash_ff;
   logic                 wr_acc;
   logic                 mapped;
   logic                 clr_in_go;
   logic                 clr_out_go;
   logic                 clr_flag_go;
   logic           [1:0] eff_mode;
   logic [ERB_WCW-1:0]   wa;
   logic [ERB_WCW-1:0]   wb;
   logic [ERB_WCW-1:0]   wmax;
   logic                 oreg_a;
   logic                 oreg_b;
   logic                 flow_eff;
   logic                 old_ok;
   logic                 one_port;
   logic                 a_rd_ok;
   logic                 b_rd_ok;
   logic                 b_wr_ok;
   logic                 a_wren_g;
   logic                 a_rden_g;
   logic                 b_wren_g;
   logic                 b_rden_g;
   logic                 a_wren_ff;
   logic                 b_wren_ff;
   logic        [AW-1:0] a_waddr_ff;
   logic        [AW-1:0] b_waddr_ff;
   logic        [DW-1:0] a_wdata_ff;
   logic        [DW-1:0] b_wdata_ff;
   logic        [AW-1:0] a_raddr;
   logic        [AW-1:0] b_raddr;
   logic        [AW-1:0] a_wbase;
   logic        [AW-1:0] a_rbase;
   logic        [AW-1:0] b_wbase;
   logic        [AW-1:0] b_rbase;
   logic                 a_wr_go;
   logic                 b_wr_go;
   logic                 w_clash;
   logic                 b_rdw;
   logic        [DW-1:0] arr_a;
   logic        [DW-1:0] arr_b;
   logic        [DW-1:0] b_old;
   logic        [DW-1:0] a_wd_m;
   logic       [TOT-1:0] mem_ff;

   //******************************************************************
   // helpers
   //******************************************************************
   // clip a width code to what the data path can carry
   function automatic logic [ERB_WCW-1:0] wclip(input logic [ERB_WCW-1:0] w);
      return (int'(w) > LOG_DW) ? ERB_WCW'(LOG_DW) : w;
   endfunction

   // ones in the low 2**w bits
   function automatic logic [DW-1:0] wmask(input logic [ERB_WCW-1:0] w);
      logic [DW-1:0] r;
      r = '0;
      for (int i = 0; i < DW; i++) begin
         r[i] = (i < (1 << w));
      end
      return r;
   endfunction

   // read 2**w bits from an aligned bit address
   function automatic logic [DW-1:0] slice(input logic [TOT-1:0] m,
                                           input logic [AW-1:0] bs,
                                           input logic [ERB_WCW-1:0] w);
      logic [DW-1:0] r;
      r = '0;
      for (int i = 0; i < DW; i++) begin
         if (i < (1 << w)) begin
            r[i] = m[bs | AW'(i)];
         end
      end
      return r;
   endfunction

   // word address to bit address; split mode pins the top bit per port
   function automatic logic [AW-1:0] base(input logic [AW-1:0] ad,
                                          input logic [ERB_WCW-1:0] w,
                                          input logic split,
                                          input logic hi);
      logic [AW-1:0] r;
      r = ad << w;
      if (split) begin
         r[AW-1] = hi;
      end
      return r;
   endfunction

   //******************************************************************
   // apb slave
   //******************************************************************
   // zero wait states: every access completes in its first access cycle
   assign pready      = 1'b1;
   assign wr_acc      = psel && penable && pwrite;
   assign mapped      = (paddr == ERB_OFS_CTRL) || (paddr == ERB_OFS_STAT) ||
                        (paddr == ERB_OFS_CLR);
   assign pslverr     = psel && penable && !mapped;
   assign prdata      = prdata_ff;
   assign clr_in_go   = wr_acc && (paddr == ERB_OFS_CLR) && pwdata[ERB_CLR_IN] &&
                        (SIZE != ERB_SIZE_LARGE); // RULE10
   assign clr_out_go  = wr_acc && (paddr == ERB_OFS_CLR) && pwdata[ERB_CLR_OUT];
   assign clr_flag_go = wr_acc && (paddr == ERB_OFS_CLR) && pwdata[ERB_CLR_FLAG];

   // control register; reserved bits never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= ERB_CTRL_RST;
      end else if (wr_acc && (paddr == ERB_OFS_CTRL)) begin
         ctrl_ff <= pwdata & ERB_CTRL_MASK;
      end
   end

   // read data fetched in setup so it leaves a flop in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            ERB_OFS_CTRL: prdata_ff <= ctrl_ff;
            ERB_OFS_STAT: prdata_ff <= stat_w;
            default:      prdata_ff <= '0;
         endcase
      end
   end

   // status word
   always_comb begin
      stat_w = '0;
      stat_w[ERB_ST_MODE +: 2] = eff_mode;
      stat_w[ERB_ST_FLOW]      = flow_eff;
      stat_w[ERB_ST_CLASH]     = clash_ff;
      stat_w[ERB_ST_SIZE +: 2] = SIZE;
   end

   // sticky write clash; a new clash beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clash_ff <= 1'b0;
      end else begin
         clash_ff <= w_clash || (clash_ff && !clr_flag_go);
      end
   end

   //******************************************************************
   // mode decode
   //******************************************************************
   // unsupported requests fall back to the nearest mode the size has
   always_comb begin
      case (ctrl_ff[ERB_CTL_MODE +: 2])
         ERB_MODE_TDP: eff_mode = (SIZE == ERB_SIZE_SMALL) ? ERB_MODE_SDP : ERB_MODE_TDP; // RULE1
         ERB_MODE_DSP: eff_mode = (SIZE == ERB_SIZE_MID) ? ERB_MODE_DSP : ERB_MODE_SP;  // RULE12
         ERB_MODE_SP:  eff_mode = ERB_MODE_SP;
         default:      eff_mode = ERB_MODE_SDP;
      endcase
   end

   assign wa       = wclip(ctrl_ff[ERB_CTL_WA +: ERB_WCW]); // RULE9
   assign wb       = wclip(ctrl_ff[ERB_CTL_WB +: ERB_WCW]); // RULE9
   assign wmax     = (wa > wb) ? wa : wb;
   assign oreg_a   = ctrl_ff[ERB_CTL_OREGA];
   assign oreg_b   = ctrl_ff[ERB_CTL_OREGB];
   assign flow_eff = ctrl_ff[ERB_CTL_FLOW] && (eff_mode == ERB_MODE_SDP) &&
                     (SIZE != ERB_SIZE_LARGE); // RULE8
   // the large block cannot promise old data on a mixed-port collision
   assign old_ok   = ctrl_ff[ERB_CTL_OLD] && (SIZE != ERB_SIZE_LARGE); // RULE2
   assign one_port = (eff_mode == ERB_MODE_SP) || (eff_mode == ERB_MODE_DSP);

   // per-port permissions; in simple dual-port a writes and b reads
   assign a_rd_ok  = (eff_mode != ERB_MODE_SDP);
   assign b_rd_ok  = (eff_mode != ERB_MODE_SP);
   assign b_wr_ok  = (eff_mode == ERB_MODE_TDP) || (eff_mode == ERB_MODE_DSP); // RULE1
   assign a_wren_g = a_wren;
   // single-port: a write in the same cycle wins over the read
   assign a_rden_g = a_rden && a_rd_ok && !(one_port && a_wren); // RULE3
   assign b_wren_g = b_wren && b_wr_ok;
   assign b_rden_g = b_rden && b_rd_ok && !(one_port && b_wren);

   //******************************************************************
   // user ports
   //******************************************************************
   erb_port #(
      .AW (AW),
      .DW (DW)
   ) u_port_a (
      .pclk     (pclk),
      .presetn  (presetn),
      .clr_in   (clr_in_go),
      .clr_out  (clr_out_go),
      .flow_sel (1'b0),
      .oreg_sel (oreg_a),
      .wr_thru  (one_port),
      .addr     (a_addr),
      .wdata    (a_wdata),
      .wren     (a_wren_g),
      .rden     (a_rden_g),
      .arr_q    (arr_a),
      .wren_ff  (a_wren_ff),
      .waddr_ff (a_waddr_ff),
      .wdata_ff (a_wdata_ff),
      .raddr    (a_raddr),
      .rdata    (a_rdata)
   );

   erb_port #(
      .AW (AW),
      .DW (DW)
   ) u_port_b (
      .pclk     (pclk),
      .presetn  (presetn),
      .clr_in   (clr_in_go),
      .clr_out  (clr_out_go),
      .flow_sel (flow_eff),
      .oreg_sel (oreg_b),
      .wr_thru  (one_port),
      .addr     (b_addr),
      .wdata    (b_wdata),
      .wren     (b_wren_g),
      .rden     (b_rden_g),
      .arr_q    (arr_b),
      .wren_ff  (b_wren_ff),
      .waddr_ff (b_waddr_ff),
      .wdata_ff (b_wdata_ff),
      .raddr    (b_raddr),
      .rdata    (b_rdata)
   );

   //******************************************************************
   // array access
   //******************************************************************
   // split mode keeps a in the lower half and b in the upper half
   assign a_wbase = base(a_waddr_ff, wa, eff_mode == ERB_MODE_DSP, 1'b0); // RULE12
   assign a_rbase = base(a_raddr, wa, eff_mode == ERB_MODE_DSP, 1'b0);
   assign b_wbase = base(b_waddr_ff, wb, eff_mode == ERB_MODE_DSP, 1'b1); // RULE12
   assign b_rbase = base(b_raddr, wb, eff_mode == ERB_MODE_DSP, 1'b1);

   // strobes come only from the registered enables
   assign a_wr_go = a_wren_ff;                // RULE6
   assign b_wr_go = b_wren_ff && b_wr_ok;     // RULE6
   assign w_clash = a_wr_go && b_wr_go && ((a_wbase >> wmax) == (b_wbase >> wmax));
   assign b_rdw   = (eff_mode == ERB_MODE_SDP) && a_wr_go &&
                    ((a_wbase >> wmax) == (b_rbase >> wmax));
   assign a_wd_m  = a_wdata_ff & wmask(wa);

   // read paths; a simple dual-port colliding read without old-data support gives all ones
   assign arr_a = slice(mem_ff, a_rbase, wa);
   assign b_old = slice(mem_ff, b_rbase, wb);
   assign arr_b = (b_rdw && !old_ok) ? wmask(wb) : b_old; // RULE2

   // bit-granular storage: one index scheme serves every width pairing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ff <= '0;
      end else begin
         for (int i = 0; i < DW; i++) begin
            if (a_wr_go && (i < (1 << wa))) begin // RULE13
               mem_ff[a_wbase | AW'(i)] <= a_wdata_ff[i];
            end
         end
         // port b wins when both write the same bit
         for (int i = 0; i < DW; i++) begin
            if (b_wr_go && (i < (1 << wb))) begin // RULE1
               mem_ff[b_wbase | AW'(i)] <= b_wdata_ff[i];
            end
         end
      end
   end

   //******************************************************************
   // checks
   //******************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_sp_wr;
      (eff_mode == ERB_MODE_SP) && a_wr_go && oreg_a;
   endsequence

   sequence s_sp_quiet;
      (eff_mode == ERB_MODE_SP) && oreg_a && !a_wr_go && !clr_out_go && !clr_in_go;
   endsequence

   a_tdp_two_writes: assert property ( // RULE1
      (eff_mode == ERB_MODE_TDP) && a_wr_go && b_wr_go && !w_clash && $stable(ctrl_ff)
      |=> slice(mem_ff, $past(a_wbase), wa) == $past(a_wd_m))
      else $error("true dual-port write on port a lost");

   a_sdp_old_data: assert property ( // RULE2
      b_rdw && old_ok && oreg_b && !flow_eff && !clr_out_go
      |=> b_rdata == $past(b_old))
      else $error("simple dual-port read did not return old data");

   a_sp_write_thru: assert property ( // RULE3
      (eff_mode == ERB_MODE_SP) && a_wr_go && !oreg_a && !clr_in_go && $stable(ctrl_ff)
      |=> a_rdata == $past(a_wd_m))
      else $error("bypassed single-port output missed written data");

   a_sp_reg_lag: assert property ( // RULE4
      s_sp_wr ##1 s_sp_quiet |=> a_rdata == $past(a_wd_m, 2))
      else $error("registered single-port output wrong after write");

   a_input_regd: assert property ( // RULE5
      a_wr_go |-> $past(a_wren))
      else $error("array write without a captured write enable");

   a_self_strobe: assert property ( // RULE6
      !a_wr_go && !b_wr_go |=> $stable(mem_ff))
      else $error("array changed without an internal write strobe");

   a_oreg_pipe: assert property ( // RULE7
      oreg_a && $past(oreg_a) && !$past(clr_out_go) |-> a_rdata == $past(arr_a))
      else $error("output register did not delay array data by one cycle");

   a_flow_bypass: assert property ( // RULE8
      flow_eff |-> b_rdata == arr_b)
      else $error("flow-through read not bypassed");

   a_width_mask: assert property ( // RULE9
      $stable(wa) && !oreg_a |-> (a_rdata & ~wmask(wa)) == '0)
      else $error("read data wider than the port width");

   a_out_clear: assert property ( // RULE10
      clr_out_go && oreg_a |=> a_rdata == '0)
      else $error("output register clear had no effect");

   a_split_halves: assert property ( // RULE12
      eff_mode == ERB_MODE_DSP |-> !a_wbase[AW-1] && !a_rbase[AW-1] &&
                                   b_wbase[AW-1] && b_rbase[AW-1])
      else $error("split single-port memories overlap");
endmodule // erb_ram
`default_nettype wire

// ==== tb/erb_user.sv ====
// erb_user: fabric user logic that drives both ram ports
`timescale 1ns/1ps
`default_nettype none
module erb_user #(
   parameter int AW = 9,
   parameter int DW = 16
) (
   input  wire logic          pclk,
   output logic      [AW-1:0] a_addr,
   output logic      [DW-1:0] a_wdata,
   output logic               a_wren,
   output logic               a_rden,
   output logic      [AW-1:0] b_addr,
   output logic      [DW-1:0] b_wdata,
   output logic               b_wren,
   output logic               b_rden
);
   // quiet lines at time zero
   initial begin
      {a_addr, a_wdata, a_wren, a_rden} = '0;
      {b_addr, b_wdata, b_wren, b_rden} = '0;
   end
   // one cycle on both ports; unused lines flip so stale values never look valid
   // rom use is just writing once and never raising wren again
   task automatic cyc(input logic aw, ar, input logic [AW-1:0] aa, input logic [DW-1:0] ad,
                      input logic bw, br, input logic [AW-1:0] ba, input logic [DW-1:0] bd);
      @(posedge pclk);
      a_wren  <= aw;
      a_rden  <= ar;
      a_addr  <= (aw | ar) ? aa : ~a_addr;
      a_wdata <= aw ? ad : ~a_wdata;
      b_wren  <= bw;
      b_rden  <= br;
      b_addr  <= (bw | br) ? ba : ~b_addr;
      b_wdata <= bw ? bd : ~b_wdata;
   endtask
endmodule // erb_user
`default_nettype wire

// ==== tb/tb.sv ====
// tb: self-checking bench for the embedded ram block
`timescale 1ns/1ps
`default_nettype none
module tb
   import erb_pkg::*;
;
   localparam int AW = 9;
   localparam int DW = 16;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [AW-1:0] a_addr, b_addr, aa, ba;
   logic [DW-1:0] a_wdata, b_wdata, a_rdata, b_rdata, ad, bd;
   logic          a_wren, a_rden, b_wren, b_rden;
   logic [DW-1:0] mem [32];
   int            failures, num_checks;

   //****************
   // parts
   //****************
   erb_ram #(.SIZE(ERB_SIZE_MID), .DEPTH(32), .DW(DW)) u_erb_ram (.pclk, .presetn, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .a_addr, .a_wdata, .a_wren, .a_rden,
      .a_rdata, .b_addr, .b_wdata, .b_wren, .b_rden, .b_rdata);
   erb_user #(.AW(AW), .DW(DW)) u_erb_user (.pclk, .a_addr, .a_wdata, .a_wren, .a_rden, .b_addr,
      .b_wdata, .b_wren, .b_rden);
   // 125 mhz clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   //****************
   // helpers
   //****************
   task automatic end_sim();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string m);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // apb master; a missing pready ends the run
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         failures++;
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // ctrl word from mode, flag nibble {old, flow, oreg_b, oreg_a} and width codes
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [3:0] f, input logic [2:0] wa, wb);
      return {17'h0, wb, 1'b0, wa, f, 2'h0, m};
   endfunction
   task automatic idle(input int n);
      repeat (n) u_erb_user.cyc(0, 0, 0, 0, 0, 0, 0, 0);
   endtask

   //****************
   // main sequence
   //****************
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      failures = 0;
      num_checks = 0;
      foreach (mem[i]) mem[i] = '0;
      void'($urandom(57));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      chk(a_rdata, 0, "a out at reset");
      chk(b_rdata, 0, "b out at reset");
      // register map, reserved bits and unmapped space
      apb(0, ERB_OFS_CTRL, 0);
      chk(rd, ERB_CTRL_RST, "ctrl reset");
      apb(0, ERB_OFS_STAT, 0);
      chk(rd, {26'h0, ERB_SIZE_MID, 4'h0}, "stat reset");
      apb(0, 12'h00c, 0);
      chk({rd[30:0], er}, 32'h1, "unmapped");
      apb(1, ERB_OFS_CTRL, 32'hffff_ffff);
      apb(0, ERB_OFS_CTRL, 0);
      chk(rd, ERB_CTRL_MASK, "ctrl mask");
      apb(0, ERB_OFS_CLR, 0);
      chk(rd, 0, "clr reads zero");
      // true dual: two writes per cycle, then two reads per cycle
      apb(1, ERB_OFS_CTRL, ctl(ERB_MODE_TDP, 4'h0, 4, 4));
      for (int i = 0; i < 24; i++) begin
         aa = $urandom_range(31);
         ba = (i == 0) ? aa : $urandom_range(31);
         ad = $urandom;
         bd = $urandom;
         u_erb_user.cyc(1, 0, aa, ad, 1, 0, ba, bd);
         mem[aa] = ad;
         mem[ba] = bd;
      end
      idle(2);
      for (int i = 0; i < 32; i++) begin
         u_erb_user.cyc(0, 1, i[AW-1:0], 0, 0, 1, 31 - i, 0);
         idle(1);
         #1;
         chk(a_rdata, mem[i], "tdp read a");
         chk(b_rdata, mem[31-i], "tdp read b");
      end
      apb(0, ERB_OFS_STAT, 0);
      chk(rd & 32'h8, 32'h8, "clash flag set");
      apb(1, ERB_OFS_CLR, 32'h1 << ERB_CLR_FLAG);
      apb(0, ERB_OFS_STAT, 0);
      chk(rd & 32'h8, 32'h0, "clash flag cleared");
      // mixed width: sixteen x1 writes on a, one x16 read on b
      apb(1, ERB_OFS_CTRL, ctl(ERB_MODE_TDP, 4'h0, 0, 4));
      for (int k = 0; k < 16; k++) begin
         ad = $urandom_range(1);
         u_erb_user.cyc(1, 0, 48 + k, ad, 0, 0, 0, 0);
         mem[3][k] = ad[0];
      end
      idle(2);
      u_erb_user.cyc(0, 0, 0, 0, 0, 1, 3, 0);
      idle(1);
      #1;
      chk(b_rdata, mem[3], "mixed width");
      // two half-size memories share the block
      apb(1, ERB_OFS_CTRL, ctl(ERB_MODE_DSP, 4'h0, 4, 4));
      ad = $urandom;
      bd = ~ad;
      u_erb_user.cyc(1, 0, 5, ad, 1, 0, 5, bd);
      idle(2);
      u_erb_user.cyc(0, 1, 5, 0, 0, 1, 5, 0);
      idle(1);
      #1;
      chk(a_rdata, ad, "lower half");
      chk(b_rdata, bd, "upper half");
      mem[5] = ad;
      mem[21] = bd;
      // single port, bypassed then registered; port b write must be ignored
      for (int r = 0; r < 2; r++) begin
         apb(1, ERB_OFS_CTRL, ctl(ERB_MODE_SP, {3'h0, r[0]}, 4, 4));
         ad = $urandom;
         bd = mem[7];
         u_erb_user.cyc(1, 0, 7, ad, 1, 0, 7, ~ad);
         idle(2);
         #1;
         chk(a_rdata, r ? bd : ad, "sp second cycle");
         idle(1);
         #1;
         chk(a_rdata, ad, "sp third cycle");
         mem[7] = ad;
      end
      // output clear empties the registered port a until its next edge
      apb(1, ERB_OFS_CLR, 32'h1 << ERB_CLR_OUT);
      #1;
      chk(a_rdata, 0, "output clear");
      // simple dual read during write: registered old data, then bypassed don't-care ones
      for (int o = 1; o >= 0; o--) begin
         apb(1, ERB_OFS_CTRL, ctl(ERB_MODE_SDP, {o[0], 1'b0, o[0], 1'b0}, 4, 4));
         ad = $urandom;
         u_erb_user.cyc(1, 0, 9, ad, 0, 1, 9, 0);
         idle(1 + o);
         #1;
         chk(b_rdata, o ? mem[9] : 16'hffff, "read during write");
         idle(1);
         #1;
         chk(b_rdata, ad, "after write");
         mem[9] = ad;
      end
      // flow-through: data before the edge that ends the read cycle
      apb(1, ERB_OFS_CTRL, ctl(ERB_MODE_SDP, 4'h4, 4, 4));
      apb(0, ERB_OFS_STAT, 0);
      chk(rd & 32'h4, 32'h4, "flow active");
      u_erb_user.cyc(0, 0, 0, 0, 0, 1, 12, 0);
      @(negedge pclk);
      #1;
      chk(b_rdata, mem[12], "flow read");
      idle(2);
      end_sim();
   end
endmodule // tb
`default_nettype wire
